/* rtl/link_err_irq_vector.v */
// Link error interrupt vector: enables, summary flags, error limit and the active-low interrupt line.
//
// Notes on behaviour
// - Disparity enable bit 7 and any lane count at limit drive irq_n low.
// - Invalid symbol enable bit 6 and any lane count at limit drive irq_n low.
// - Stray control enable bit 5 and any lane count at limit drive irq_n low.
// - Lane alignment enable bit 3 and any enabled lane alignment failure drive irq_n low.
// - Checksum enable bit 2 and any enabled lane checksum failure drive irq_n low.
// - Frame enable bit 1 and any enabled lane frame loss drive irq_n low.
// - Symbol lock enable bit 0 and any enabled lane lock failure drive irq_n low.
// - Summary bit 7 reads one while any lane disparity count reached the limit.
// - Summary bit 6 reads one while any lane invalid symbol count reached the limit.
// - Summary bit 5 reads one while any lane stray control count reached the limit.
// - Summary bit 3 reads one while any enabled lane alignment failure is latched.
// - Summary bit 2 reads one while any enabled lane checksum failure is latched.
// - Summary bit 1 reads one while any enabled lane frame loss is latched.
// - Summary bit 0 reads one while any enabled lane code group failure is latched.
// - One address: writes set enables, reads give summary, reset zero, bit 4 zero.
// - All lane counts share one eight-bit limit, reset to 0xFF.
`timescale 1ns/1ns
`include "link_irq_consts.vh"
module link_err_irq_vector #(
  parameter LANES = `DEFAULT_LANES,
  parameter CW    = `COUNT_W
) (
  input  wire                   sys_clk,                 // Register clock, 125 MHz.
  input  wire                   rstn,                    // Asynchronous device reset, active low.
  input  wire [`REG_ADDR_W-1:0] reg_addr,                // Register address.
  input  wire                   reg_wr,                  // Write strobe, one cycle.
  input  wire [7:0]             reg_wdata,               // Write data.
  input  wire                   reg_rd,                  // Read strobe, one cycle.
  output reg  [7:0]             reg_rdata,               // Read data, valid the cycle after reg_rd.
  input  wire [LANES*CW-1:0]    disparity_err_count,     // Per-lane bad disparity counts.
  input  wire [LANES*CW-1:0]    invalid_symbol_count,    // Per-lane not-in-table counts.
  input  wire [LANES*CW-1:0]    stray_control_char_count, // Per-lane unexpected control counts.
  input  wire [LANES-1:0]       lane_align_fail,         // Latched per-lane alignment failures.
  input  wire [LANES-1:0]       config_sum_fail,         // Latched per-lane checksum failures.
  input  wire [LANES-1:0]       frame_align_fail,        // Latched per-lane frame losses.
  input  wire [LANES-1:0]       symbol_lock_fail,        // Latched per-lane code group failures.
  input  wire [LANES-1:0]       lane_enable,             // Lanes in use.
  output wire [LANES-1:0]       disparity_err_lanes,     // Lanes at limit, bad disparity.
  output wire [LANES-1:0]       invalid_symbol_lanes,    // Lanes at limit, not in table.
  output wire [LANES-1:0]       stray_control_char_lanes, // Lanes at limit, unexpected control.
  output reg  [7:0]             error_count_limit,       // Shared error limit for the sync logic.
  output reg                    irq_n                    // Interrupt line, active low.
);

  reg  [7:0] link_irq_enable_reg;
  wire [7:0] link_irq_summary;
  wire       disparity_err_pending;
  wire       invalid_symbol_pending;
  wire       stray_control_char_pending;
  wire [3:0] fail_summary;
  reg  [7:0] rdata_next;

  wire [CW-1:0] limit_w;

  // The limit register is eight bits; a wider count sees it zero-extended, a narrower one its low part.
  generate
    if (CW > 8)
    begin : g_limit_pad
      assign limit_w = {{(CW-8){1'b0}}, error_count_limit};
    end
    else
    begin : g_limit_cut
      assign limit_w = error_count_limit[CW-1:0];
    end
  endgenerate

  lane_limit_cmp #(
    .LANES (LANES),
    .CW    (CW)
  ) u_disparity_cmp (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .lane_counts (disparity_err_count),
    .limit       (limit_w),
    .hit_lanes   (disparity_err_lanes),
    .any_hit     (disparity_err_pending)
  );

  lane_limit_cmp #(
    .LANES (LANES),
    .CW    (CW)
  ) u_invalid_symbol_cmp (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .lane_counts (invalid_symbol_count),
    .limit       (limit_w),
    .hit_lanes   (invalid_symbol_lanes),
    .any_hit     (invalid_symbol_pending)
  );

  lane_limit_cmp #(
    .LANES (LANES),
    .CW    (CW)
  ) u_stray_ctrl_cmp (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .lane_counts (stray_control_char_count),
    .limit       (limit_w),
    .hit_lanes   (stray_control_char_lanes),
    .any_hit     (stray_control_char_pending)
  );

  // Latched lane failures stay until software clears them at the lane status registers.
  lane_fail_summary #(
    .LANES (LANES)
  ) u_fail_summary (
    .sys_clk          (sys_clk),
    .rstn             (rstn),
    .lane_align_fail  (lane_align_fail),
    .config_sum_fail  (config_sum_fail),
    .frame_align_fail (frame_align_fail),
    .symbol_lock_fail (symbol_lock_fail),
    .lane_enable      (lane_enable),
    .fail_summary     (fail_summary)
  );

  assign link_irq_summary[`BIT_DISPARITY]      = disparity_err_pending;
  assign link_irq_summary[`BIT_INVALID_SYMBOL] = invalid_symbol_pending;
  assign link_irq_summary[`BIT_STRAY_CTRL]     = stray_control_char_pending;
  assign link_irq_summary[`BIT_RESERVED]       = 1'b0;
  assign link_irq_summary[`BIT_LANE_ALIGN]     = fail_summary[3];
  assign link_irq_summary[`BIT_CONFIG_SUM]     = fail_summary[2];
  assign link_irq_summary[`BIT_FRAME_ALIGN]    = fail_summary[1];
  assign link_irq_summary[`BIT_SYMBOL_LOCK]    = fail_summary[0];

  // Enable bits are write-only; their only visible effect is on irq_n.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      link_irq_enable_reg <= `IRQ_ENABLE_RESET;
    else if (reg_wr && (reg_addr == `IRQ_VECTOR_ADDR))
      link_irq_enable_reg <= reg_wdata & `IRQ_ENABLE_WMASK;
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      error_count_limit <= `ERR_LIMIT_RESET;
    else if (reg_wr && (reg_addr == `ERR_LIMIT_ADDR))
      error_count_limit <= reg_wdata;
  end

  always @*
  begin
    case (reg_addr)
      `IRQ_VECTOR_ADDR: rdata_next = link_irq_summary;
      `ERR_LIMIT_ADDR:  rdata_next = error_count_limit;
      default:          rdata_next = `RDATA_UNMAPPED;
    endcase
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

  // One source per bit; the reserved bit can never fire because its enable is held at zero.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      irq_n <= 1'b1;
    else
      irq_n <= ~|(link_irq_summary & link_irq_enable_reg);
  end

endmodule

/* rtl/link_irq_consts.vh */
// Register offsets, field positions and reset values of the link interrupt vector.
`ifndef LINK_IRQ_CONSTS_VH
`define LINK_IRQ_CONSTS_VH

`define REG_ADDR_W           12
`define IRQ_VECTOR_ADDR      12'h47A
`define ERR_LIMIT_ADDR       12'h47C
`define CODE_GRP_STATUS_ADDR 12'h470
`define FRAME_STATUS_ADDR    12'h471
`define CHECKSUM_STATUS_ADDR 12'h472
`define LANE_ALIGN_STAT_ADDR 12'h473
`define DISP_LANES_ADDR      12'h46D
`define NIT_LANES_ADDR       12'h46E
`define UCC_LANES_ADDR       12'h46F

`define BIT_DISPARITY        7
`define BIT_INVALID_SYMBOL   6
`define BIT_STRAY_CTRL       5
`define BIT_RESERVED         4
`define BIT_LANE_ALIGN       3
`define BIT_CONFIG_SUM       2
`define BIT_FRAME_ALIGN      1
`define BIT_SYMBOL_LOCK      0

`define IRQ_ENABLE_RESET     8'h00
`define IRQ_SUMMARY_RESET    8'h00
`define IRQ_ENABLE_WMASK     8'hEF
`define ERR_LIMIT_RESET      8'hFF
`define RDATA_UNMAPPED       8'h00

`define DEFAULT_LANES        8
`define COUNT_W              8

`endif

/* rtl/lane_limit_cmp.v */
// Compares every lane's error count against the shared limit and reports hits.
`timescale 1ns/1ns
module lane_limit_cmp #(
  parameter LANES = 8,
  parameter CW    = 8
) (
  input  wire                sys_clk,     // Register clock.
  input  wire                rstn,        // Asynchronous reset, active low.
  input  wire [LANES*CW-1:0] lane_counts, // Packed per-lane error counts, lane 0 in the low bits.
  input  wire [CW-1:0]       limit,       // Shared error count limit.
  output reg  [LANES-1:0]    hit_lanes,   // Lanes whose count has reached the limit.
  output reg                 any_hit      // At least one lane has reached the limit.
);

  wire [LANES-1:0] hit_w;

  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1)
    begin : g_lane
      // Reaching the limit counts, so equality already raises the hit.
      assign hit_w[i] = (lane_counts[i*CW +: CW] >= limit);
    end
  endgenerate

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hit_lanes <= {LANES{1'b0}};
      any_hit   <= 1'b0;
    end
    else
    begin
      hit_lanes <= hit_w;
      any_hit   <= |hit_w;
    end
  end

endmodule

/* rtl/lane_fail_summary.v */
// Folds the latched per-lane synchronisation failures into four summary bits.
`timescale 1ns/1ns
module lane_fail_summary #(
  parameter LANES = 8
) (
  input  wire             sys_clk,          // Register clock.
  input  wire             rstn,             // Asynchronous reset, active low.
  input  wire [LANES-1:0] lane_align_fail,  // Latched initial lane alignment failure per lane.
  input  wire [LANES-1:0] config_sum_fail,  // Latched checksum failure per lane.
  input  wire [LANES-1:0] frame_align_fail, // Latched frame alignment loss per lane.
  input  wire [LANES-1:0] symbol_lock_fail, // Latched code group sync failure per lane.
  input  wire [LANES-1:0] lane_enable,      // Lanes in use; unused lanes never report.
  output reg  [3:0]       fail_summary      // Bits 3..0: align, checksum, frame, code group.
);

  function any_enabled;
    input [LANES-1:0] fail;
    input [LANES-1:0] en;
    begin
      any_enabled = |(fail & en);
    end
  endfunction

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      fail_summary <= 4'h0;
    else
    begin
      fail_summary[3] <= any_enabled(lane_align_fail, lane_enable);
      fail_summary[2] <= any_enabled(config_sum_fail, lane_enable);
      fail_summary[1] <= any_enabled(frame_align_fail, lane_enable);
      fail_summary[0] <= any_enabled(symbol_lock_fail, lane_enable);
    end
  end

endmodule

/* dv/link_irq_checker_assertions.sv */
// Port-level checks of the link error interrupt vector.
`timescale 1ns/1ns
module link_irq_checker #(
  parameter LANES = 8,
  parameter CW    = 8
) (
  input wire                sys_clk,                  // Clock.
  input wire                rstn,                     // Reset.
  input wire [11:0]         reg_addr,                 // Address.
  input wire                reg_wr,                   // Write.
  input wire [7:0]          reg_wdata,                // Data.
  input wire                reg_rd,                   // Read.
  input wire [7:0]          reg_rdata,                // Data.
  input wire [LANES*CW-1:0] disparity_err_count,      // Counts.
  input wire [LANES*CW-1:0] invalid_symbol_count,     // Counts.
  input wire [LANES*CW-1:0] stray_control_char_count, // Counts.
  input wire [LANES-1:0]    lane_align_fail,          // Fails.
  input wire [LANES-1:0]    config_sum_fail,          // Fails.
  input wire [LANES-1:0]    frame_align_fail,         // Fails.
  input wire [LANES-1:0]    symbol_lock_fail,         // Fails.
  input wire [LANES-1:0]    lane_enable,              // Lanes.
  input wire [LANES-1:0]    disparity_err_lanes,      // Hits.
  input wire [LANES-1:0]    invalid_symbol_lanes,     // Hits.
  input wire [LANES-1:0]    stray_control_char_lanes, // Hits.
  input wire [7:0]          error_count_limit,        // Limit.
  input wire                irq_n                     // Irq.
);
  function [LANES-1:0] hits(input [LANES*CW-1:0] c, input [7:0] l);
    integer i;
    for (i = 0; i < LANES; i = i + 1)
      hits[i] = c[i*CW+:CW] >= l;
  endfunction
  wire [LANES-1:0] disp_c = hits(disparity_err_count, error_count_limit);
  wire [LANES-1:0] inval_c = hits(invalid_symbol_count, error_count_limit);
  wire [LANES-1:0] stray_c = hits(stray_control_char_count, error_count_limit);
  wire [7:0] summ_c = {|disp_c, |inval_c, |stray_c, 1'b0, |(lane_align_fail & lane_enable),
    |(config_sum_fail & lane_enable), |(frame_align_fail & lane_enable), |(symbol_lock_fail & lane_enable)};
  reg [7:0] en_reg;
  reg [7:0] summ_reg;
  reg       irq_exp_reg;
  // The model trails the design by the same two register stages so both agree cycle by cycle.
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      en_reg <= 8'h00;
      summ_reg <= 8'h00;
      irq_exp_reg <= 1'b1;
    end
    else
    begin
      if (reg_wr && reg_addr == 12'h47A)
        en_reg <= reg_wdata & 8'hEF;
      summ_reg <= summ_c;
      irq_exp_reg <= ~|(en_reg & summ_reg);
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  irq_vector_a: assert property (irq_n == irq_exp_reg)
    else $error("irq line disagrees with enabled flags");
  irq_idle_a: assert property (!$past(rstn) |-> irq_n ##1 (irq_n || $past(reg_wr)))
    else $error("irq low right after reset");
  disp_lanes_a: assert property ($past(rstn) |-> disparity_err_lanes == $past(disp_c))
    else $error("disparity lanes wrong");
  inval_lanes_a: assert property ($past(rstn) |-> invalid_symbol_lanes == $past(inval_c))
    else $error("invalid symbol lanes wrong");
  stray_lanes_a: assert property ($past(rstn) |-> stray_control_char_lanes == $past(stray_c))
    else $error("stray control lanes wrong");
  summary_read_a: assert property (reg_rd && reg_addr == 12'h47A |=> reg_rdata == $past(summ_reg))
    else $error("summary read wrong");
  limit_reset_a: assert property (!$past(rstn) |-> error_count_limit == 8'hFF)
    else $error("limit reset wrong");
  limit_write_a: assert property (reg_wr && reg_addr == 12'h47C |=> error_count_limit == $past(reg_wdata))
    else $error("limit write lost");
  limit_read_a: assert property (reg_rd && reg_addr == 12'h47C |=> reg_rdata == $past(error_count_limit))
    else $error("limit read wrong");
  unmapped_read_a: assert property (reg_rd && reg_addr != 12'h47A && reg_addr != 12'h47C |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  irq_low_c: cover property ($fell(irq_n));
  summary_c: cover property (reg_rd && reg_addr == 12'h47A ##1 reg_rdata != 8'h00);
  limit_c: cover property (reg_wr && reg_addr == 12'h47C);
endmodule

bind link_err_irq_vector link_irq_checker #(.LANES(LANES), .CW(CW)) link_irq_checker_inst (.sys_clk, .rstn,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .disparity_err_count, .invalid_symbol_count,
  .stray_control_char_count, .lane_align_fail, .config_sum_fail, .frame_align_fail, .symbol_lock_fail,
  .lane_enable, .disparity_err_lanes, .invalid_symbol_lanes, .stray_control_char_lanes, .error_count_limit,
  .irq_n);

/* dv/lane_status_model.sv */
// Lane status holder: latches per-lane failures until software clears them.
`timescale 1ns/1ns
module lane_status_model #(
  parameter LANES = 8
) (
  input  wire               sys_clk,    // Clock.
  input  wire               rstn,       // Reset, active low.
  input  wire [3:0]         fail_set,   // Kinds to latch, index equals summary bit.
  input  wire [LANES-1:0]   fail_lanes, // Lanes that fail.
  input  wire [3:0]         clr,        // Bit 7 written to each status register.
  output reg  [4*LANES-1:0] fail_vec    // Latched failures per kind.
);
  integer k;
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
      fail_vec <= {4*LANES{1'b0}};
    else
      for (k = 0; k < 4; k = k + 1)
        if (clr[k])
          fail_vec[k*LANES+:LANES] <= {LANES{1'b0}};
        else if (fail_set[k])
          fail_vec[k*LANES+:LANES] <= fail_vec[k*LANES+:LANES] | fail_lanes;
endmodule

/* dv/test_serial_link_error_irq_vector.sv */
// Register-level test of the link error interrupt vector.
`timescale 1ns/1ns
module test_serial_link_error_irq_vector;
  reg         sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
  reg [11:0]  reg_addr = 12'h000;
  reg [7:0]   reg_wdata = 8'h00;
  reg [191:0] cnts = 192'h0;
  reg [3:0]   fail_set = 4'h0, clr = 4'h0;
  reg [7:0]   fail_lanes = 8'h00, lane_enable = 8'h0F;
  wire [31:0] fail_vec;
  wire [7:0]  rdata, limit, dlanes;
  wire        irq_n;
  integer     n_errors = 0, samples_checked = 0, cycles = 0, b;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  lane_status_model lane_status_model_inst (.sys_clk(sys_clk), .rstn(rstn), .fail_set(fail_set),
    .fail_lanes(fail_lanes), .clr(clr), .fail_vec(fail_vec));
  link_err_irq_vector link_err_irq_vector_inst (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata),
    .disparity_err_count(cnts[63:0]), .invalid_symbol_count(cnts[127:64]),
    .stray_control_char_count(cnts[191:128]), .lane_align_fail(fail_vec[31:24]),
    .config_sum_fail(fail_vec[23:16]), .frame_align_fail(fail_vec[15:8]), .symbol_lock_fail(fail_vec[7:0]),
    .lane_enable(lane_enable), .disparity_err_lanes(dlanes), .invalid_symbol_lanes(),
    .stray_control_char_lanes(), .error_count_limit(limit), .irq_n(irq_n));
  task chk(input [7:0] seen, input [7:0] exp, input [8*12:1] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      tick(1);
      reg_wr = 0;
      // An idle edge keeps a following call from raising a strobe in the step that lowered it.
      tick(1);
    end
  endtask
  task rd(input [11:0] a, input [7:0] e, input [8*12:1] what);
    begin
      reg_addr = a;
      reg_rd = 1;
      tick(1);
      reg_rd = 0;
      chk(rdata, e, what);
      tick(1);
    end
  endtask
  // Counts sit on lane 3, one below the limit when idle, so the boundary is exercised.
  task cause(input integer k, input on);
    begin
      if (k >= 5)
        cnts[(7-k)*64+24+:8] = on ? 8'h10 : 8'h0F;
      else if (on)
        fail_set[k] = 1;
      else
        clr[k] = 1;
      tick(1);
      fail_set = 4'h0;
      clr = 4'h0;
      tick(2);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial
  begin
    tick(3);
    rstn = 1;
    rd(12'h47C, 8'hFF, "limit");
    rd(12'h47A, 8'h00, "summary");
    rd(12'h123, 8'h00, "unmapped");
    wr(12'h47C, 8'h10);
    rd(12'h47C, 8'h10, "limit");
    fail_lanes = 8'h08;
    for (b = 0; b < 8; b = b + 1)
      if (b != 4)
      begin
        wr(12'h47A, 8'hFF ^ (8'h01 << b));
        cause(b, 1);
        chk(irq_n, 1, "masked irq");
        rd(12'h47A, 8'h01 << b, "summary");
        if (b == 7)
          chk(dlanes, 8'h08, "lanes");
        wr(12'h47A, 8'h01 << b);
        tick(1);
        chk(irq_n, 0, "irq");
        cause(b, 0);
        chk(irq_n, 1, "idle irq");
      end
    // Only the lane failure kinds are enabled, so the gating check below can really trip.
    wr(12'h47A, 8'h0F);
    fail_lanes = 8'h80;
    fail_set = 4'hF;
    tick(3);
    chk(irq_n, 1, "off lane");
    lane_enable = 8'hFF;
    tick(2);
    chk(irq_n, 0, "on lane");
    rd(12'h47A, 8'h0F, "summary");
    wrap_up;
  end
endmodule
